// file: vhiu_host.sv
// vhiu_host: host controller model, wishbone master and setup steps
// assumes the slave answers every request with ack_i or err_i
`timescale 1ns/1ps
module vhiu_host
	import vhiu_pkg::*;
(
	// clock and answer
	input  wire logic        clk_i,
	input  wire logic        ack_i,
	input  wire logic        err_i,
	input  wire logic [31:0] rdat_i,
	// request
	output logic             cyc_o,
	output logic             stb_o,
	output logic             we_o,
	output logic      [7:0]  adr_o,
	output logic      [3:0]  sel_o,
	output logic      [31:0] wdat_o
);
	logic [31:0] rdat;
	logic        rerr;
	// bus idle from time zero
	initial {cyc_o, stb_o, we_o, adr_o, sel_o, wdat_o} = '0;
	// one cycle, held until the answer edge, answer taken there
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		sel_o <= 4'hf;
		wdat_o <= d;
		// no cycle count assumed; only the bench watchdog ends a hang
		do begin
			@(posedge clk_i);
		end while (ack_i !== 1'b1 && err_i !== 1'b1);
		rdat = rdat_i;
		rerr = err_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
	endtask : bus
	task automatic setup(input logic [31:0] c1, input logic [31:0] c2);
		bus(1'b1, VHIU_INT_ENABLE, 32'h1);
		bus(1'b0, VHIU_INT_SET, 32'h0);
		bus(1'b1, VHIU_INT_CLEAR, rdat);
		bus(1'b1, VHIU_FRAME_RATE, 32'h8);
		bus(1'b1, VHIU_START1, 32'h1000);
		bus(1'b1, VHIU_CONFIG1, c1);
		bus(1'b1, VHIU_START2, 32'h2000);
		bus(1'b1, VHIU_CONFIG2, c2);
		bus(1'b1, VHIU_CONTROL, 32'h21);
	endtask : setup
endmodule : vhiu_host

// file: vhiu_irq.sv
// vhiu_irq: sticky pending bits, enable mask, registered level irq
// assumes set pulses and clear strobes on the same clock
`timescale 1ns/1ps
module vhiu_irq #(
	parameter int N = 2
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// event and software side
	input  wire logic [N-1:0] set_i,
	input  wire logic [N-1:0] clear_i,
	input  wire logic [N-1:0] enable_i,
	// state out
	output logic      [N-1:0] pending_o,
	output logic              irq_o
);
	// ones clear bits; zeros ignored, set wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pending_o <= '0;
		end else begin
			pending_o <= (pending_o & ~clear_i) | set_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(pending_o & enable_i);
		end
	end
endmodule : vhiu_irq

// file: vhiu_monitor.sv
// vhiu_monitor: port assertions for vhiu_top
// assumes one clock, sync reset and a classic wishbone master
`timescale 1ns/1ps
module vhiu_monitor
	import vhiu_pkg::*;
(
	// watched ports
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	input  wire logic [31:0] dat_o,
	input  wire logic        ack_o,
	input  wire logic        err_o,
	input  wire logic        irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// misaligned offsets left out: their answer is not pinned down
	wire take = cyc_i && stb_i && !ack_o && !err_o;
	wire hit = adr_i < 8'h0c || (adr_i >= 8'h60 && adr_i <= 8'h78);
	wire irq_wr = ack_o && we_i && (adr_i == VHIU_INT_CLEAR || adr_i == VHIU_INT_ENABLE);
	wire en_off = ack_o && we_i && sel_i[0] && adr_i == VHIU_INT_ENABLE && dat_i[1:0] == 2'h0;
	// bus answer shape
	ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held");
	err_pulse_a: assert property (err_o |=> !err_o) else $error("err held");
	mapped_ack_a: assert property (take && hit && adr_i[1:0] == 2'h0 |=> ack_o && !err_o)
		else $error("mapped access not acked");
	unmapped_err_a: assert property (take && !hit && adr_i[1:0] == 2'h0 |=> err_o && !ack_o)
		else $error("unmapped access not refused");
	idle_data_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data idle");
	// irq drops only after software touched clear or enable
	irq_fall_a: assert property ($fell(irq_o) |-> $past(irq_wr) || $past(irq_wr, 2) || $past(irq_wr, 3))
		else $error("irq fell uncaused");
	mask_off_a: assert property (en_off |-> ##2 !irq_o)
		else $error("masked irq still high");
	irq_level_a: assert property ($rose(irq_o) |=> irq_o)
		else $error("irq not level");
endmodule : vhiu_monitor

bind vhiu_top vhiu_monitor i_mon (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.err_o(err_o), .irq_o(irq_o)
);

// file: vhiu_pkg.sv
// vhiu_pkg: constants shared by the video handoff interrupt unit
// assumes a 32-bit classic wishbone slave and one 100 MHz clock
package vhiu_pkg;
	// register byte offsets
	localparam logic [7:0] VHIU_INT_CLEAR  = 8'h00;
	localparam logic [7:0] VHIU_INT_SET    = 8'h04;
	localparam logic [7:0] VHIU_INT_ENABLE = 8'h08;
	localparam logic [7:0] VHIU_FRAME_RATE = 8'h60;
	localparam logic [7:0] VHIU_START1     = 8'h64;
	localparam logic [7:0] VHIU_CONFIG1    = 8'h68;
	localparam logic [7:0] VHIU_START2     = 8'h6c;
	localparam logic [7:0] VHIU_CONFIG2    = 8'h70;
	localparam logic [7:0] VHIU_CONTROL    = 8'h74;
	localparam logic [7:0] VHIU_STATUS     = 8'h78;
	// interrupt source bit positions
	localparam int VHIU_SRC_CFG_DONE  = 0;
	localparam int VHIU_SRC_LOOP_DONE = 1;
	localparam int VHIU_NSRC          = 2;
	// control word fields
	localparam int VHIU_CTL_PLAY     = 0;
	localparam int VHIU_CTL_STOP     = 1;
	localparam int VHIU_CTL_AUTOSTOP = 2;
	localparam int VHIU_CTL_POINTER  = 3;
	localparam int VHIU_CTL_LOOP     = 4;
	localparam int VHIU_CTL_TOGGLE   = 5;
	// config word fields: frames in low half, loops in high half
	localparam int VHIU_CFG_FRAMES_LSB = 0;
	localparam int VHIU_CFG_LOOPS_LSB  = 16;
	localparam int VHIU_CFG_FIELD_W    = 16;
	// reset values
	localparam logic [31:0] VHIU_RST_FRAME_RATE = 32'h0000_0100;
	localparam logic [31:0] VHIU_RST_ZERO       = 32'h0000_0000;
	// sequencer states
	typedef enum logic [1:0] {VHIU_IDLE, VHIU_PLAY, VHIU_FROZEN} vhiu_state_t;
endpackage : vhiu_pkg

// file: vhiu_seq.sv
// vhiu_seq: two-slot playback sequencer, frame timing by clock count
// assumes registers written on the same clock; a frame is frame_rate clocks
`timescale 1ns/1ps
module vhiu_seq
	import vhiu_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// programmed settings
	input  wire logic [31:0] frame_rate_i,
	input  wire logic [31:0] start1_i,
	input  wire logic [31:0] config1_i,
	input  wire logic [31:0] start2_i,
	input  wire logic [31:0] config2_i,
	input  wire logic [5:0]  ctl_i,
	input  wire logic        ctl_wr_i,
	// progress out
	output logic             cfg_done_o,
	output logic             loop_done_o,
	output logic             active_slot_o,
	output logic [31:0]      frame_addr_o,
	output logic             display_on_o,
	output vhiu_state_t      state_o
);
	logic [31:0] clk_cnt;
	logic [15:0] frame_cnt;
	logic [15:0] loop_cnt;
	logic [15:0] cur_frames;
	logic [15:0] cur_loops;
	logic [31:0] cur_start;
	logic        restart;
	logic        end_armed;
	logic        frame_tick;

	// frame boundary from the programmed clock count
	assign frame_tick = (clk_cnt + 32'h1 >= frame_rate_i);

	always_ff @(posedge clk_i) begin
		if (rst_i || state_o != VHIU_PLAY || frame_tick) begin
			clk_cnt <= '0;
		end else begin
			clk_cnt <= clk_cnt + 32'h1;
		end
	end

	// play while running waits for next frame
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			restart <= 1'b0;
		end else if (ctl_wr_i && ctl_i[VHIU_CTL_PLAY] && state_o == VHIU_PLAY) begin
			restart <= 1'b1;
		end else if (frame_tick || state_o != VHIU_PLAY) begin
			// a stop must not leave a stale restart for the next run
			restart <= 1'b0;
		end
	end

	// play-clear write arms the end action for the current slot
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			end_armed <= 1'b0;
		end else if (ctl_wr_i && !ctl_i[VHIU_CTL_PLAY] && !ctl_i[VHIU_CTL_STOP]
			&& state_o == VHIU_PLAY) begin
			end_armed <= 1'b1;
		end else if (ctl_wr_i || state_o != VHIU_PLAY) begin
			end_armed <= 1'b0;
		end
	end

	// slot sequencing; start and config read only at slot start, frame rate and control read live
	always_ff @(posedge clk_i) begin
		cfg_done_o  <= 1'b0;
		loop_done_o <= 1'b0;
		if (rst_i) begin
			state_o       <= VHIU_IDLE;
			active_slot_o <= 1'b0;
			frame_cnt     <= '0;
			loop_cnt      <= '0;
			cur_frames    <= '0;
			cur_loops     <= '0;
			cur_start     <= '0;
			frame_addr_o  <= '0;
			display_on_o  <= 1'b0;
		end else if (ctl_wr_i && ctl_i[VHIU_CTL_STOP]) begin
			state_o      <= VHIU_IDLE;
			display_on_o <= 1'b0;
		end else if ((ctl_wr_i && ctl_i[VHIU_CTL_PLAY] && state_o != VHIU_PLAY)
			|| (restart && frame_tick)) begin
			active_slot_o <= ctl_i[VHIU_CTL_POINTER];
			cur_start     <= ctl_i[VHIU_CTL_POINTER] ? start2_i : start1_i;
			cur_frames    <= ctl_i[VHIU_CTL_POINTER] ? config2_i[VHIU_CFG_FRAMES_LSB +: VHIU_CFG_FIELD_W]
			                                          : config1_i[VHIU_CFG_FRAMES_LSB +: VHIU_CFG_FIELD_W];
			cur_loops     <= ctl_i[VHIU_CTL_POINTER] ? config2_i[VHIU_CFG_LOOPS_LSB +: VHIU_CFG_FIELD_W]
			                                          : config1_i[VHIU_CFG_LOOPS_LSB +: VHIU_CFG_FIELD_W];
			frame_addr_o  <= ctl_i[VHIU_CTL_POINTER] ? start2_i : start1_i;
			frame_cnt     <= '0;
			loop_cnt      <= '0;
			state_o       <= VHIU_PLAY;
			display_on_o  <= 1'b1;
		end else if (state_o == VHIU_PLAY && frame_tick) begin
			if (frame_cnt + 16'h1 < cur_frames) begin
				frame_cnt    <= frame_cnt + 16'h1;
				frame_addr_o <= frame_addr_o + 32'h1;
			end else if (loop_cnt + 16'h1 < cur_loops) begin
				// another pass of the same slot
				loop_cnt     <= loop_cnt + 16'h1;
				frame_cnt    <= '0;
				frame_addr_o <= cur_start;
				loop_done_o  <= 1'b1;
			end else begin
				loop_done_o <= 1'b1;
				// toggle without loop keeps alternating until an end is armed
				if (ctl_i[VHIU_CTL_TOGGLE] && (ctl_i[VHIU_CTL_LOOP] || !end_armed)) begin
					// switch slot, raise event; capture other slot
					cfg_done_o    <= 1'b1;
					active_slot_o <= ~active_slot_o;
					cur_start     <= active_slot_o ? start1_i : start2_i;
					frame_addr_o  <= active_slot_o ? start1_i : start2_i;
					cur_frames    <= active_slot_o ? config1_i[VHIU_CFG_FRAMES_LSB +: VHIU_CFG_FIELD_W]
					                               : config2_i[VHIU_CFG_FRAMES_LSB +: VHIU_CFG_FIELD_W];
					cur_loops     <= active_slot_o ? config1_i[VHIU_CFG_LOOPS_LSB +: VHIU_CFG_FIELD_W]
					                               : config2_i[VHIU_CFG_LOOPS_LSB +: VHIU_CFG_FIELD_W];
					frame_cnt     <= '0;
					loop_cnt      <= '0;
				end else if (ctl_i[VHIU_CTL_LOOP]) begin
					// repeat one slot, re-capturing its settings
					cfg_done_o   <= 1'b1;
					cur_start    <= active_slot_o ? start2_i : start1_i;
					frame_addr_o <= active_slot_o ? start2_i : start1_i;
					cur_frames   <= active_slot_o ? config2_i[VHIU_CFG_FRAMES_LSB +: VHIU_CFG_FIELD_W]
					                              : config1_i[VHIU_CFG_FRAMES_LSB +: VHIU_CFG_FIELD_W];
					cur_loops    <= active_slot_o ? config2_i[VHIU_CFG_LOOPS_LSB +: VHIU_CFG_FIELD_W]
					                              : config1_i[VHIU_CFG_LOOPS_LSB +: VHIU_CFG_FIELD_W];
					frame_cnt    <= '0;
					loop_cnt     <= '0;
				end else begin
					// auto-stop: dark, else freeze last frame
					cfg_done_o   <= 1'b1;
					state_o      <= ctl_i[VHIU_CTL_AUTOSTOP] ? VHIU_IDLE : VHIU_FROZEN;
					display_on_o <= ~ctl_i[VHIU_CTL_AUTOSTOP];
				end
			end
		end
	end
endmodule : vhiu_seq

// file: vhiu_tb.sv
// tb: self-checking bench for vhiu_top
// assumes vhiu_host as master; frame period cut to 8 clocks
`timescale 1ns/1ps
module tb;
	import vhiu_pkg::*;
	logic        clk_i;
	logic        rst_i;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic        ack;
	logic        err;
	logic        irq;
	logic        disp;
	logic [31:0] faddr;
	logic [31:0] p;
	int          errors;
	int          checks;
	// clock and reset
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		rst_i = 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
	end
	vhiu_host i_host (.clk_i(clk_i), .ack_i(ack), .err_i(err), .rdat_i(rdat), .cyc_o(cyc),
		.stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .wdat_o(wdat));
	vhiu_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .err_o(err),
		.irq_o(irq), .display_on_o(disp), .frame_addr_o(faddr));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			errors++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask : chk
	// 0 irq, 1 display, else frame address page
	function automatic logic [31:0] get(input int k);
		case (k)
			0: return {31'h0, irq};
			1: return {31'h0, disp};
			default: return {12'h0, faddr[31:12]};
		endcase
	endfunction : get
	task automatic waitv(input int k, input logic [31:0] v, input int lim);
		repeat (lim) if (get(k) !== v) @(posedge clk_i);
	endtask : waitv
	task automatic results;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results
	// watchdog, far beyond the run length
	initial begin
		repeat (4000) @(posedge clk_i);
		errors++;
		results();
	end
	initial begin
		errors = 0;
		checks = 0;
		@(negedge rst_i);
		@(posedge clk_i);
		chk(get(0), 32'h0);
		chk(get(1), 32'h0);
		i_host.bus(1'b0, VHIU_INT_ENABLE, 32'h0);
		chk(i_host.rdat, VHIU_RST_ZERO);
		i_host.bus(1'b0, VHIU_FRAME_RATE, 32'h0);
		chk(i_host.rdat, VHIU_RST_FRAME_RATE);
		i_host.bus(1'b0, 8'h10, 32'h0);
		chk({31'h0, i_host.rerr}, 32'h1);
		$display("test registers done");
		// handoff: flagged switch, reload idle slot, clear
		i_host.setup(32'h0001_0003, 32'h0001_0004);
		waitv(0, 32'h1, 200);
		chk(get(0), 32'h1);
		chk(get(2), 32'h2);
		i_host.bus(1'b0, VHIU_INT_SET, 32'h0);
		p = i_host.rdat;
		chk(p & 32'h1, 32'h1);
		i_host.bus(1'b1, VHIU_START1, 32'h3000);
		i_host.bus(1'b1, VHIU_CONFIG1, 32'h0001_0002);
		chk(get(2), 32'h2);
		i_host.bus(1'b1, VHIU_INT_CLEAR, p);
		repeat (3) @(posedge clk_i);
		chk(get(0), 32'h0);
		waitv(0, 32'h1, 200);
		repeat (2) @(posedge clk_i);
		chk(get(2), 32'h3);
		$display("test handoff done");
		// masked source latches but stays off the line
		i_host.bus(1'b1, VHIU_INT_ENABLE, 32'h0);
		i_host.bus(1'b1, VHIU_INT_CLEAR, 32'h3);
		repeat (40) @(posedge clk_i);
		chk(get(0), 32'h0);
		i_host.bus(1'b0, VHIU_INT_SET, 32'h0);
		chk(i_host.rdat & 32'h1, 32'h1);
		i_host.bus(1'b1, VHIU_INT_ENABLE, 32'h1);
		repeat (3) @(posedge clk_i);
		chk(get(0), 32'h1);
		$display("test mask done");
		// end behaviour, restart on pointer, stop
		i_host.bus(1'b1, VHIU_CONTROL, 32'h24);
		chk(get(1), 32'h1);
		waitv(1, 32'h0, 200);
		chk(get(1), 32'h0);
		i_host.bus(1'b1, VHIU_CONFIG1, 32'h0001_0008);
		i_host.bus(1'b1, VHIU_CONTROL, 32'h21);
		waitv(2, 32'h3, 20);
		chk(get(2), 32'h3);
		i_host.bus(1'b1, VHIU_CONTROL, 32'h29);
		waitv(2, 32'h2, 12);
		chk(get(2), 32'h2);
		i_host.bus(1'b1, VHIU_CONTROL, 32'h2);
		waitv(1, 32'h0, 10);
		chk(get(1), 32'h0);
		$display("test control done");
		results();
	end
endmodule : tb

// file: vhiu_top.sv
// vhiu_top: wishbone register file, interrupt unit and video sequencer
// assumes a classic wishbone master, 32-bit words, one 100 MHz clock
`timescale 1ns/1ps
module vhiu_top
	import vhiu_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	output logic             err_o,
	// host interrupt and display
	output logic             irq_o,
	output logic             display_on_o,
	output logic [31:0]      frame_addr_o
);
	import vhiu_pkg::*;

	logic [31:0]         frame_rate;
	logic [31:0]         start1;
	logic [31:0]         config1;
	logic [31:0]         start2;
	logic [31:0]         config2;
	logic [5:0]          ctl;
	logic [VHIU_NSRC-1:0] int_enable;
	logic [VHIU_NSRC-1:0] int_clear;
	logic [VHIU_NSRC-1:0] pending;
	logic                 ctl_wr;
	logic                 cfg_done;
	logic                 loop_done;
	logic                 active_slot;
	logic                 irq_w;
	logic                 disp_w;
	logic [31:0]          faddr_w;
	vhiu_state_t          state;
	logic                 req;
	logic                 wr;
	logic                 mapped;

	// byte-lane merge used by the frame rate, start and config registers; control and enable take lane 0 only
	function automatic logic [31:0] vhiu_merge(input logic [31:0] old,
		input logic [31:0] din, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) r[8*i +: 8] = din[8*i +: 8];
		end
		return r;
	endfunction : vhiu_merge

	// one request per ack; ack low the cycle after
	assign req    = cyc_i && stb_i && !ack_o && !err_o;
	assign wr     = req && we_i && mapped;
	assign mapped = adr_i inside {VHIU_INT_CLEAR, VHIU_INT_SET, VHIU_INT_ENABLE,
		VHIU_FRAME_RATE, VHIU_START1, VHIU_CONFIG1, VHIU_START2, VHIU_CONFIG2,
		VHIU_CONTROL, VHIU_STATUS};
	assign ctl_wr = wr && adr_i == VHIU_CONTROL && sel_i[0];
	// clear strobe only on clear writes
	assign int_clear = (wr && adr_i == VHIU_INT_CLEAR && sel_i[0])
		? dat_i[VHIU_NSRC-1:0] : '0;

	// writable registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frame_rate <= VHIU_RST_FRAME_RATE;
			start1     <= VHIU_RST_ZERO;
			config1    <= VHIU_RST_ZERO;
			start2     <= VHIU_RST_ZERO;
			config2    <= VHIU_RST_ZERO;
			ctl        <= '0;
			int_enable <= '0;
		end else if (wr) begin
			case (adr_i)
				VHIU_FRAME_RATE: frame_rate <= vhiu_merge(frame_rate, dat_i, sel_i);
				VHIU_START1:     start1     <= vhiu_merge(start1, dat_i, sel_i);
				VHIU_CONFIG1:    config1    <= vhiu_merge(config1, dat_i, sel_i);
				VHIU_START2:     start2     <= vhiu_merge(start2, dat_i, sel_i);
				VHIU_CONFIG2:    config2    <= vhiu_merge(config2, dat_i, sel_i);
				VHIU_CONTROL:    if (sel_i[0]) ctl <= dat_i[5:0];
				VHIU_INT_ENABLE: if (sel_i[0]) int_enable <= dat_i[VHIU_NSRC-1:0];
				default:         ;
			endcase
		end
	end

	// bus answer: one cycle after request, err on unmapped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
			dat_o <= '0;
		end else begin
			ack_o <= req && mapped;
			err_o <= req && !mapped;
			dat_o <= '0;
			if (req && !we_i) begin
				case (adr_i)
					VHIU_INT_SET:    dat_o <= {{(32-VHIU_NSRC){1'b0}}, pending};
					VHIU_INT_ENABLE: dat_o <= {{(32-VHIU_NSRC){1'b0}}, int_enable};
					VHIU_FRAME_RATE: dat_o <= frame_rate;
					VHIU_START1:     dat_o <= start1;
					VHIU_CONFIG1:    dat_o <= config1;
					VHIU_START2:     dat_o <= start2;
					VHIU_CONFIG2:    dat_o <= config2;
					VHIU_CONTROL:    dat_o <= {26'h0, ctl};
					VHIU_STATUS:     dat_o <= {28'h0, state, active_slot,
						state == VHIU_PLAY};
					default:         dat_o <= '0;
				endcase
			end
		end
	end

	vhiu_irq #(.N(VHIU_NSRC)) u_irq (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.set_i     ({loop_done, cfg_done}),
		.clear_i   (int_clear),
		.enable_i  (int_enable),
		.pending_o (pending),
		.irq_o     (irq_w)
	);

	// sequencer sees the new control word in the write cycle
	vhiu_seq u_seq (
		.clk_i         (clk_i),
		.rst_i         (rst_i),
		.frame_rate_i  (frame_rate),
		.start1_i      (start1),
		.config1_i     (config1),
		.start2_i      (start2),
		.config2_i     (config2),
		.ctl_i         (ctl_wr ? dat_i[5:0] : ctl),
		.ctl_wr_i      (ctl_wr),
		.cfg_done_o    (cfg_done),
		.loop_done_o   (loop_done),
		.active_slot_o (active_slot),
		.frame_addr_o  (faddr_w),
		.display_on_o  (disp_w),
		.state_o       (state)
	);

	// outputs straight from submodule flops
	assign irq_o        = irq_w;
	assign display_on_o = disp_w;
	assign frame_addr_o = faddr_w;
endmodule : vhiu_top
